// ==== core/status_led_pkg.sv ====
// Shared constants and types for the camera status indicator
package status_led_pkg;

	// Clock and timing
	localparam int unsigned     CLK_FREQ_HZ       = 125_000_000;
	localparam int unsigned     CLK_PER_MS        = CLK_FREQ_HZ / 1000;
	localparam int unsigned     ACQ_GAP_MS        = 100;
	localparam int unsigned     ACQ_GAP_CYCLES    = ACQ_GAP_MS * CLK_PER_MS;
	localparam int unsigned     REBOOT_TIME_MS    = 30000;
	localparam longint unsigned REBOOT_CYCLES_DEF = longint'(REBOOT_TIME_MS) * CLK_PER_MS;

	// Register map (byte addresses)
	localparam int          ADDR_W      = 4;
	localparam logic [3:0]  COND_OFS    = 4'h0;
	localparam logic [3:0]  FLASH_OFS   = 4'h4;
	localparam logic [3:0]  STATUS_OFS  = 4'h8;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// Condition register bits
	localparam int COND_INIT  = 0;
	localparam int COND_FATAL = 1;
	localparam int COND_XFER  = 2;
	localparam int COND_ACQ   = 3;
	localparam int COND_IP    = 4;
	localparam int COND_APP   = 5;
	localparam int COND_W     = 6;

	// Flash configuration fields, half periods in milliseconds
	localparam int          HALF_W    = 16;
	localparam int          SLOW_LSB  = 0;
	localparam int          FAST_LSB  = 16;
	localparam logic [15:0] SLOW_RST  = 16'h01F4;
	localparam logic [15:0] FAST_RST  = 16'h0064;

	// Status register fields
	localparam int ST_DISP_LSB = 0;
	localparam int ST_DISP_W   = 4;
	localparam int ST_LINK     = 4;
	localparam int ST_HOST     = 5;
	localparam int ST_STARTED  = 6;
	localparam int ST_RED      = 8;
	localparam int ST_GREEN    = 9;
	localparam int ST_BLUE     = 10;

	typedef enum logic [3:0] {
		D_POWERUP,
		D_FATAL,
		D_INIT,
		D_XFER,
		D_NOLINK,
		D_ACQ,
		D_APP,
		D_IP,
		D_IDLE
	} disp_type;

endpackage : status_led_pkg

// ==== core/flash_phase.sv ====
// Flash phase generator: toggles every programmed number of millisecond ticks
`timescale 1ns/1ps
module flash_phase
(
	// Clock and reset
	input  wire logic                           clk,
	input  wire logic                           srst,
	// Timing
	input  wire logic                           tick,
	input  wire logic [status_led_pkg::HALF_W-1:0] half_period,
	// Phase
	output logic                                phase
);
	import status_led_pkg::*;

	typedef struct packed {
		logic [HALF_W-1:0] cnt;
		logic              phase;
	} fl_state_type;

	fl_state_type st_reg;
	fl_state_type st_next;

	always_comb
	begin
		st_next = st_reg;
		if (tick)
		begin
			// A zero half period behaves as one, so the lamp never freezes
			if (st_reg.cnt + HALF_W'(1) >= half_period)
			begin
				st_next.cnt   = '0;
				st_next.phase = !st_reg.phase;
			end
			else
			begin
				st_next.cnt = st_reg.cnt + HALF_W'(1);
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign phase = st_reg.phase;

endmodule : flash_phase

// ==== core/status_led.sv ====
// Camera status indicator: priority selection, flashing and register slave
//
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
module status_led
#(
	parameter int unsigned     MS_CYCLES     = status_led_pkg::CLK_PER_MS,
	parameter int unsigned     GAP_CYCLES    = status_led_pkg::ACQ_GAP_CYCLES,
	parameter longint unsigned REBOOT_CYCLES = status_led_pkg::REBOOT_CYCLES_DEF
)
(
	// Clock and reset
	input  wire logic                              REF_CLK,
	input  wire logic                              SRST,
	// AXI4-Lite write address and data
	input  wire logic [status_led_pkg::ADDR_W-1:0] AWADDR,
	input  wire logic                              AWVALID,
	output logic                                   AWREADY,
	input  wire logic [31:0]                       WDATA,
	input  wire logic [3:0]                        WSTRB,
	input  wire logic                              WVALID,
	output logic                                   WREADY,
	// AXI4-Lite write response
	output logic [1:0]                             BRESP,
	output logic                                   BVALID,
	input  wire logic                              BREADY,
	// AXI4-Lite read
	input  wire logic [status_led_pkg::ADDR_W-1:0] ARADDR,
	input  wire logic                              ARVALID,
	output logic                                   ARREADY,
	output logic [31:0]                            RDATA,
	output logic [1:0]                             RRESP,
	output logic                                   RVALID,
	input  wire logic                              RREADY,
	// Camera pins
	input  wire logic                              LINK_UP,
	input  wire logic                              FRAME_EVT,
	// Indicator and system outputs
	output logic                                   LED_RED,
	output logic                                   LED_GREEN,
	output logic                                   LED_BLUE,
	output logic                                   HOST_ACCESS_EN,
	output logic                                   ADDR_CFG_START,
	output logic                                   REBOOT_REQ
);
	import status_led_pkg::*;

	localparam int MS_W  = $clog2(MS_CYCLES + 1);
	localparam int GAP_W = $clog2(GAP_CYCLES + 1);
	localparam logic [MS_W-1:0]  MS_LAST  = MS_W'(MS_CYCLES - 1);
	localparam logic [GAP_W-1:0] GAP_LOAD = GAP_W'(GAP_CYCLES - 1);
	localparam logic [31:0]      RB_LAST  = 32'(REBOOT_CYCLES - 1);
	localparam logic [31:0]      RB_PULSE = 32'(REBOOT_CYCLES - 2);

	typedef struct packed {
		logic              aw_ready;
		logic              w_ready;
		logic              b_valid;
		logic [1:0]        b_resp;
		logic              ar_ready;
		logic              r_valid;
		logic [31:0]       r_data;
		logic [1:0]        r_resp;
		logic              aw_full;
		logic              w_full;
		logic [ADDR_W-1:0] aw_addr;
		logic [31:0]       w_data;
		logic [3:0]        w_strb;
		logic [COND_W-1:0] cond;
		logic [HALF_W-1:0] slow_half;
		logic [HALF_W-1:0] fast_half;
		logic              link_s1;
		logic              link_s2;
		logic              link_prev;
		logic              frm_s1;
		logic              frm_s2;
		logic              frm_prev;
		logic [MS_W-1:0]   ms_cnt;
		logic              ms_tick;
		logic [GAP_W-1:0]  gap_cnt;
		logic              green_ph;
		logic [31:0]       reboot_cnt;
		logic              reboot_req;
		logic              por_done;
		logic              cfg_start;
		logic              started;
		disp_type          disp;
		logic              led_r;
		logic              led_g;
		logic              led_b;
		logic              host_en;
	} st_type;

	st_type st_reg;
	st_type st_next;
	logic   slow_ph;
	logic   fast_ph;

	function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
		input logic [31:0] new_val, input logic [3:0] strb);
		logic [31:0] res;
		res = old_val;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				res[i*8 +: 8] = new_val[i*8 +: 8];
		end
		return res;
	endfunction : merge_bytes

	// Both rates share one millisecond tick, so their ratio is set by software alone
	flash_phase u_slow
	(
		.clk         (REF_CLK),
		.srst        (SRST),
		.tick        (st_reg.ms_tick),
		.half_period (st_reg.slow_half),
		.phase       (slow_ph)
	);

	flash_phase u_fast
	(
		.clk         (REF_CLK),
		.srst        (SRST),
		.tick        (st_reg.ms_tick),
		.half_period (st_reg.fast_half),
		.phase       (fast_ph)
	);

	always_comb
	begin
		logic [31:0] rd;
		logic [31:0] flash_word;
		rd = '0;
		flash_word = '0;
		st_next = st_reg;

		// Pin synchronisers
		st_next.link_s1   = LINK_UP;
		st_next.link_s2   = st_reg.link_s1;
		st_next.link_prev = st_reg.link_s2;
		st_next.frm_s1    = FRAME_EVT;
		st_next.frm_s2    = st_reg.frm_s1;
		st_next.frm_prev  = st_reg.frm_s2;

		// Write channel: address and data are taken in either order
		if (AWVALID && st_reg.aw_ready)
		begin
			st_next.aw_full = 1'b1;
			st_next.aw_addr = AWADDR;
		end
		if (WVALID && st_reg.w_ready)
		begin
			st_next.w_full = 1'b1;
			st_next.w_data = WDATA;
			st_next.w_strb = WSTRB;
		end
		if (st_reg.b_valid && BREADY)
			st_next.b_valid = 1'b0;
		if (st_reg.aw_full && st_reg.w_full && !st_reg.b_valid)
		begin
			st_next.aw_full = 1'b0;
			st_next.w_full  = 1'b0;
			st_next.b_valid = 1'b1;
			st_next.b_resp  = RESP_OKAY;
			flash_word[SLOW_LSB +: HALF_W] = st_reg.slow_half;
			flash_word[FAST_LSB +: HALF_W] = st_reg.fast_half;
			if (st_reg.aw_addr == COND_OFS)
				st_next.cond = COND_W'(merge_bytes(32'(st_reg.cond), st_reg.w_data,
					st_reg.w_strb));
			else if (st_reg.aw_addr == FLASH_OFS)
			begin
				flash_word = merge_bytes(flash_word, st_reg.w_data, st_reg.w_strb);
				st_next.slow_half = flash_word[SLOW_LSB +: HALF_W];
				st_next.fast_half = flash_word[FAST_LSB +: HALF_W];
			end
			else if (st_reg.aw_addr != STATUS_OFS)
				st_next.b_resp = RESP_SLVERR;
		end
		st_next.aw_ready = !st_next.aw_full && !st_next.b_valid;
		st_next.w_ready  = !st_next.w_full && !st_next.b_valid;

		// Read channel
		if (ARVALID && st_reg.ar_ready)
		begin
			st_next.r_valid = 1'b1;
			st_next.r_resp  = RESP_OKAY;
			if (ARADDR == COND_OFS)
				rd = 32'(st_reg.cond);
			else if (ARADDR == FLASH_OFS)
			begin
				rd[SLOW_LSB +: HALF_W] = st_reg.slow_half;
				rd[FAST_LSB +: HALF_W] = st_reg.fast_half;
			end
			else if (ARADDR == STATUS_OFS)
			begin
				rd[ST_DISP_LSB +: ST_DISP_W] = ST_DISP_W'(st_reg.disp);
				rd[ST_LINK]    = st_reg.link_s2;
				rd[ST_HOST]    = st_reg.host_en;
				rd[ST_STARTED] = st_reg.started;
				rd[ST_RED]     = st_reg.led_r;
				rd[ST_GREEN]   = st_reg.led_g;
				rd[ST_BLUE]    = st_reg.led_b;
			end
			else
				st_next.r_resp = RESP_SLVERR;
			st_next.r_data = rd;
		end
		else if (st_reg.r_valid && RREADY)
			st_next.r_valid = 1'b0;
		st_next.ar_ready = !st_next.r_valid;

		// Millisecond tick for the flash dividers
		st_next.ms_tick = 1'b0;
		if (st_reg.ms_cnt >= MS_LAST)
		begin
			st_next.ms_cnt  = '0;
			st_next.ms_tick = 1'b1;
		end
		else
			st_next.ms_cnt = st_reg.ms_cnt + MS_W'(1);

		// Frame toggles; events inside the hold-off are dropped, not queued
		if (st_reg.gap_cnt != '0)
			st_next.gap_cnt = st_reg.gap_cnt - GAP_W'(1);
		if (!st_reg.cond[COND_ACQ])
			st_next.green_ph = 1'b1;
		else if (st_reg.frm_s2 && !st_reg.frm_prev && st_reg.gap_cnt == '0)
		begin
			st_next.green_ph = !st_reg.green_ph;
			st_next.gap_cnt  = GAP_LOAD;
		end

		// Restart request once a fatal error has persisted
		st_next.reboot_req = 1'b0;
		if (st_reg.cond[COND_FATAL])
		begin
			if (st_reg.reboot_cnt != RB_LAST)
				st_next.reboot_cnt = st_reg.reboot_cnt + 32'h0000_0001;
			st_next.reboot_req = (st_reg.reboot_cnt == RB_PULSE);
		end
		else
			st_next.reboot_cnt = '0;

		// Address configuration kick at power-up and on each link rise
		st_next.por_done  = 1'b1;
		st_next.cfg_start = !st_reg.por_done || (st_reg.link_s2 && !st_reg.link_prev);

		// Host access follows the address-assigned flag
		st_next.host_en = st_reg.cond[COND_IP];

		// Priority selection
		if (st_reg.cond != '0)
			st_next.started = 1'b1;
		if (st_reg.cond[COND_FATAL])
			st_next.disp = D_FATAL;
		else if (st_reg.cond[COND_INIT])
			st_next.disp = D_INIT;
		else if (!st_reg.started)
			st_next.disp = D_POWERUP;
		else if (st_reg.cond[COND_XFER])
			st_next.disp = D_XFER;
		else if (!st_reg.link_s2)
			st_next.disp = D_NOLINK;
		else if (st_reg.cond[COND_ACQ])
			st_next.disp = D_ACQ;
		else if (st_reg.cond[COND_APP])
			st_next.disp = D_APP;
		else if (st_reg.cond[COND_IP])
			st_next.disp = D_IP;
		else
			st_next.disp = D_IDLE;

		st_next.led_r = 1'b0;
		st_next.led_g = 1'b0;
		st_next.led_b = 1'b0;
		case (st_next.disp)
			D_POWERUP: st_next.led_r = 1'b1;
			D_FATAL:
			begin
				st_next.led_r = 1'b1;
				st_next.led_b = slow_ph;
			end
			D_INIT:    st_next.led_r = slow_ph;
			D_XFER:    st_next.led_b = fast_ph;
			D_NOLINK:  st_next.led_b = slow_ph;
			D_ACQ:     st_next.led_g = st_reg.green_ph;
			D_APP:     st_next.led_g = 1'b1;
			D_IP:      st_next.led_b = 1'b1;
			default:   st_next.led_b = 1'b0;
		endcase
	end

	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
		begin
			st_reg           <= '0;
			// Idle, not power-up, so no state claims red before the first update
			st_reg.disp      <= D_IDLE;
			st_reg.slow_half <= SLOW_RST;
			st_reg.fast_half <= FAST_RST;
		end
		else
			st_reg <= st_next;
	end

	assign AWREADY        = st_reg.aw_ready;
	assign WREADY         = st_reg.w_ready;
	assign BRESP          = st_reg.b_resp;
	assign BVALID         = st_reg.b_valid;
	assign ARREADY        = st_reg.ar_ready;
	assign RDATA          = st_reg.r_data;
	assign RRESP          = st_reg.r_resp;
	assign RVALID         = st_reg.r_valid;
	assign LED_RED        = st_reg.led_r;
	assign LED_GREEN      = st_reg.led_g;
	assign LED_BLUE       = st_reg.led_b;
	assign HOST_ACCESS_EN = st_reg.host_en;
	assign ADDR_CFG_START = st_reg.cfg_start;
	assign REBOOT_REQ     = st_reg.reboot_req;

	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (SRST);

	sequence link_rise;
		!st_reg.link_s2 ##1 st_reg.link_s2;
	endsequence

	sequence acq_over_ip;
		st_reg.started && st_reg.link_s2 && st_reg.cond[COND_ACQ] && st_reg.cond[COND_IP]
			&& !st_reg.cond[COND_FATAL] && !st_reg.cond[COND_INIT] && !st_reg.cond[COND_XFER];
	endsequence

	AST_ACQ_WINS: assert property (acq_over_ip |=> st_reg.disp == D_ACQ && !LED_BLUE)
		else $error("Acquisition did not take priority over address");
	AST_POWERUP_RED: assert property (st_reg.disp == D_POWERUP |-> LED_RED && !LED_GREEN
		&& !LED_BLUE)
		else $error("Power-up indication is not steady red");
	AST_INIT_FLASH: assert property (st_reg.cond[COND_INIT] && !st_reg.cond[COND_FATAL]
		|=> LED_RED == $past(slow_ph) && !LED_GREEN)
		else $error("Initialisation is not flashing red");
	AST_FATAL_RED: assert property (st_reg.cond[COND_FATAL] |=> LED_RED
		&& LED_BLUE == $past(slow_ph))
		else $error("Fatal error indication wrong");
	AST_REBOOT_CAUSE: assert property (REBOOT_REQ |-> $past(st_reg.cond[COND_FATAL])
		&& $past(st_reg.reboot_cnt) == RB_PULSE)
		else $error("Restart request without persisting fatal error");
	AST_NOLINK_SLOW: assert property (st_reg.disp == D_NOLINK |-> !LED_RED && !LED_GREEN
		&& LED_BLUE == $past(slow_ph))
		else $error("Disconnected cable is not slow blue");
	AST_XFER_FAST: assert property (st_reg.disp == D_XFER |-> !LED_RED && !LED_GREEN
		&& LED_BLUE == $past(fast_ph))
		else $error("File transfer is not fast blue");
	AST_IP_BLUE: assert property (st_reg.disp == D_IP |-> LED_BLUE && !LED_RED
		&& !LED_GREEN)
		else $error("Assigned address is not steady blue");
	AST_HOST_GATE: assert property (HOST_ACCESS_EN |-> $past(st_reg.cond[COND_IP]))
		else $error("Host access without assigned address");
	AST_GREEN_RATE: assert property ($past(st_reg.cond[COND_ACQ]) && $changed(st_reg.green_ph)
		|-> $past(st_reg.gap_cnt) == '0 && st_reg.gap_cnt == GAP_LOAD)
		else $error("Green toggle inside hold-off");
	AST_CFG_LINK: assert property (link_rise |=> ADDR_CFG_START)
		else $error("No address configuration start on link rise");
	AST_APP_GREEN: assert property (st_reg.disp == D_APP |-> LED_GREEN && !LED_RED
		&& !LED_BLUE)
		else $error("Connected application is not steady green");

endmodule : status_led

// ==== test/led_watch.sv ====
// Partner model: the status LED, counting colour changes
`timescale 1ns/1ps
module led_watch
(
	// Clock and control
	input  wire logic clk,
	input  wire logic clear,
	// LED drives
	input  wire logic red,
	input  wire logic green,
	input  wire logic blue,
	// Observations
	output int        n_red,
	output int        n_green,
	output int        n_blue,
	output int        gap_min
);
	logic [2:0] last;
	int         since;

	// Gap is counted in edges between two green changes
	always @(posedge clk)
	begin
		last <= {red, green, blue};
		since <= since + 1;
		if (clear)
		begin
			n_red <= 0;
			n_green <= 0;
			n_blue <= 0;
			gap_min <= 1000000;
		end
		else
		begin
			if (red !== last[2])
				n_red <= n_red + 1;
			if (blue !== last[0])
				n_blue <= n_blue + 1;
			if (green !== last[1])
			begin
				n_green <= n_green + 1;
				since <= 0;
				if (n_green > 0 && since + 1 < gap_min)
					gap_min <= since + 1;
			end
		end
	end
endmodule : led_watch

// ==== test/status_led_tb.sv ====
// Self-checking bench for the camera status indicator
`timescale 1ns/1ps
module status_led_tb;
	import status_led_pkg::*;
	localparam int MS  = 4;
	localparam int GAP = 20;
	localparam int RBT = 50;
	logic        clk, srst, awvalid, wvalid, arvalid, link_up, frame_evt, clear, seen;
	logic        awready, wready, bvalid, arready, rvalid, red, green, blue;
	logic        host_en, cfg_start, reboot;
	logic [3:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [1:0]  bresp, rresp, r;
	logic [6:0]  cases [10];
	int          failures, tests_run, seed, n, n_r, n_g, n_b, gmin;

	status_led #(.MS_CYCLES(MS), .GAP_CYCLES(GAP), .REBOOT_CYCLES(RBT)) status_led_i (
		.REF_CLK(clk), .SRST(srst), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
		.WDATA(wdata), .WSTRB(4'hF), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
		.BVALID(bvalid), .BREADY(1'b1), .ARADDR(araddr), .ARVALID(arvalid),
		.ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(1'b1),
		.LINK_UP(link_up), .FRAME_EVT(frame_evt), .LED_RED(red), .LED_GREEN(green),
		.LED_BLUE(blue), .HOST_ACCESS_EN(host_en), .ADDR_CFG_START(cfg_start),
		.REBOOT_REQ(reboot));

	led_watch led_watch_i (.clk(clk), .clear(clear), .red(red), .green(green), .blue(blue),
		.n_red(n_r), .n_green(n_g), .n_blue(n_b), .gap_min(gmin));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			failures++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic chk_in(input int v, input int lo, input int hi);
		tests_run++;
		if (v < lo || v > hi)
		begin
			failures++;
			$display("BAD %0t got %h exp %h..%h", $time, v, lo, hi);
		end
	endtask : chk_in

	// Ready is sampled at the edge; the slave answer ends the wait
	task automatic axw(input logic [3:0] a, input logic [31:0] dat, output logic [1:0] rsp);
		@(posedge clk);
		awaddr <= a;
		wdata <= dat;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do
		begin
			@(posedge clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1);
		rsp = bresp;
	endtask : axw

	task automatic axr(input logic [3:0] a, output logic [31:0] dat, output logic [1:0] rsp);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		do
		begin
			@(posedge clk);
			if (arready)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
		dat = rdata;
		rsp = rresp;
	endtask : axr

	function automatic disp_type exp_disp(input logic [5:0] c, input logic lk);
		if (c[COND_FATAL])
			return D_FATAL;
		if (c[COND_INIT])
			return D_INIT;
		if (!seen)
			return D_POWERUP;
		if (c[COND_XFER])
			return D_XFER;
		if (!lk)
			return D_NOLINK;
		if (c[COND_ACQ])
			return D_ACQ;
		if (c[COND_APP])
			return D_APP;
		if (c[COND_IP])
			return D_IP;
		return D_IDLE;
	endfunction : exp_disp

	// Per colour: 0 off, 1 on, 2 slow flash, 3 fast flash
	function automatic logic [5:0] modes(input disp_type e);
		case (e)
			D_POWERUP: return 6'b01_00_00;
			D_FATAL:   return 6'b01_00_10;
			D_INIT:    return 6'b10_00_00;
			D_XFER:    return 6'b00_00_11;
			D_NOLINK:  return 6'b00_00_10;
			D_ACQ:     return 6'b00_01_00;
			D_APP:     return 6'b00_01_00;
			D_IP:      return 6'b00_00_01;
			default:   return 6'b00_00_00;
		endcase
	endfunction : modes

	// Half periods of 8 and 4 cycles give 5..7 and 11..13 changes in the window
	task automatic look(input logic [1:0] m, input int cnt, input logic lvl);
		if (m < 2)
		begin
			chk_in(cnt, 0, 0);
			chk(lvl, m[0]);
		end
		else if (m == 2)
			chk_in(cnt, 5, 7);
		else
			chk_in(cnt, 11, 13);
	endtask : look

	task automatic run_case(input logic [5:0] c, input logic lk);
		disp_type   e;
		logic [5:0] m;
		if (link_up !== lk)
		begin
			@(posedge clk);
			link_up <= lk;
			repeat (4) @(posedge clk);
		end
		seen = seen | (c != 6'h00);
		e = exp_disp(c, lk);
		m = modes(e);
		axw(COND_OFS, {26'h0, c}, r);
		repeat (4) @(posedge clk);
		clear <= 1'b1;
		@(posedge clk);
		clear <= 1'b0;
		repeat (48) @(posedge clk);
		#1;
		look(m[5:4], n_r, red);
		look(m[3:2], n_g, green);
		look(m[1:0], n_b, blue);
		chk(host_en, c[COND_IP]);
		axr(STATUS_OFS, d, r);
		chk(d[3:0], e);
		$display("test case %h link %b done", c, lk);
	endtask : run_case

	task conclude;
		$display("counts: %0d checks, %0d mismatches", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : conclude

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	initial
	begin
		repeat (30000) @(posedge clk);
		failures++;
		conclude();
	end

	initial
	begin
		{awvalid, wvalid, arvalid, link_up, frame_evt, clear, seen} = '0;
		{awaddr, araddr, wdata} = '0;
		seed = 32'he200faec;
		srst = 1'b1;
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		n = 0;
		repeat (4)
		begin
			@(posedge clk);
			#1;
			n += cfg_start;
		end
		chk_in(n, 1, 1);
		chk({red, green, blue}, 3'b100);
		axr(COND_OFS, d, r);
		chk(d, 32'h0);
		axr(FLASH_OFS, d, r);
		chk(d, {FAST_RST, SLOW_RST});
		axr(STATUS_OFS, d, r);
		chk(d[3:0], D_POWERUP);
		axr(4'hC, d, r);
		chk({r, d}, {RESP_SLVERR, 32'h0});
		axw(4'hC, 32'hFFFF_FFFF, r);
		chk(r, RESP_SLVERR);
		axw(STATUS_OFS, 32'hFFFF_FFFF, r);
		chk(r, RESP_OKAY);
		axw(FLASH_OFS, 32'h0001_0002, r);
		axr(FLASH_OFS, d, r);
		chk(d, 32'h0001_0002);
		$display("test registers done");
		@(posedge clk);
		link_up <= 1'b1;
		n = 0;
		repeat (8)
		begin
			@(posedge clk);
			#1;
			n += cfg_start;
		end
		chk_in(n, 1, 1);
		$display("test link start done");
		cases = '{7'h40, 7'h52, 7'h71, 7'h5C, 7'h18, 7'h78, 7'h70, 7'h50, 7'h40, 7'h04};
		foreach (cases[i])
			run_case(cases[i][5:0], cases[i][6]);
		repeat (8)
		begin
			n = $random(seed);
			run_case(n[5:0], n[6]);
		end
		run_case(6'h18, 1'b1);
		clear <= 1'b1;
		@(posedge clk);
		clear <= 1'b0;
		repeat (100)
		begin
			@(posedge clk);
			frame_evt <= ~frame_evt;
			@(posedge clk);
		end
		#1;
		chk_in(gmin, GAP, 1000000);
		chk_in(n_g, 5, 200 / GAP + 1);
		$display("test frame rate done");
		axw(COND_OFS, 32'h2, r);
		n = 0;
		do
		begin
			@(posedge clk);
			#1;
			n++;
		end
		while (reboot !== 1'b1 && n < 200);
		chk_in(n, RBT - 5, RBT + 5);
		n = 0;
		repeat (100)
		begin
			@(posedge clk);
			#1;
			n += reboot;
		end
		chk_in(n, 0, 0);
		$display("test reboot done");
		conclude();
	end
endmodule : status_led_tb
